// ==== asc_uart.sv ====
// asc_uart: asynchronous serial channel, transmitter, receiver and cpu registers.
// assumes a byte-wide cpu port synchronous to CLK; RXD and EXT_BAUD_CLK are synchronous inputs.
//
// Function
// - frame: start, 7/8 data bits, optional parity, 1/2 stop bits, set by mode
// - 7-bit mode: transmit ignores bit 7, received bit 7 reads zero
// - even parity: total ones even on transmit, odd total flags error
// - odd parity: total ones odd on transmit, even total flags error
// - zero parity: transmit 0 parity bit, receiver never checks it
// - no parity: no parity bit sent or expected, never a parity error
// - writing transmit data starts a frame with framing bits added
// - transmit done pulse and sticky flag once all bits shifted out
// - low input starts 5-bit counter; half bit later still low means start
// - after data, parity and one stop bit, load buffer and signal done
// - erroneous data still loaded; done suppressed on error when mask set
// - clearing receive enable stops reception, no update, no interrupts
// - late disable: buffer may update with or without done interrupt
// - errors set status flags and error interrupt before receive done
// - framing error on missing stop bit, overrun on unread buffer
// - buffer read or next frame end clears status; new errors set again
// - sync control: bit 7 enable, bit 2 first-bit order, bit 1 clock source
// - parity field: 00 none, 01 zero, 10 odd, 11 even
// - char length bit 0=7/1=8 bits; stop length bit 0=1/1=2 stop bits
// - clock source bit: 0 external pin, 1 baud generator
// - internal baud rate is clock over 2^n times k plus 16
`timescale 1ns/1ps
module asc_uart
    import asc_pkg::*;
#(
    parameter int TX_DEPTH = ASC_TX_FIFO_DEPTH
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic RXD,
    output logic TXD,
    input wire logic EXT_BAUD_CLK,
    output logic TX_READY,
    output logic TRANSMIT_DONE_IRQ,
    output logic RECEIVE_DONE_IRQ,
    output logic RECEIVE_ERROR_IRQ,
    output logic SYNC_MODE_ENABLE,
    output logic FIRST_BIT_ORDER,
    output logic SYNC_CLOCK_SOURCE
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction

    function automatic logic parity_on(input asc_mode_t m);
        return m.parity != ASC_PAR_NONE;
    endfunction

    // transmit frame, lsb first, unused upper bits are idle ones
    function automatic logic [ASC_FRAME_MAX-1:0] tx_frame(input logic [7:0] d, input asc_mode_t m);
        logic [7:0] dv;
        logic par;
        dv = m.char8 ? d : {1'b0, d[6:0]};
        case (m.parity)
            ASC_PAR_EVEN: par = ^dv;
            ASC_PAR_ODD: par = ~^dv;
            default: par = 1'b0;
        endcase
        if (m.char8) begin
            return parity_on(m) ? {2'h3, par, dv, 1'b0} : {3'h7, dv, 1'b0};
        end
        return parity_on(m) ? {3'h7, par, dv[6:0], 1'b0} : {4'hf, dv[6:0], 1'b0};
    endfunction

    function automatic logic [3:0] tx_bits(input asc_mode_t m);
        // start, data, parity slot only when on, then stops
        return (m.char8 ? 4'd9 : 4'd8) + (parity_on(m) ? 4'd1 : 4'd0) + (m.stop2 ? 4'd2 : 4'd1);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // registers and decode
    asc_mode_t mode_r;
    asc_err_t err_r;
    logic [2:0] rx_err_r;
    logic tx_done_r;
    logic [7:0] baud_r;
    logic [7:0] sync_r;
    logic [7:0] rxb_r;
    logic rxb_full_r;
    logic wr_mode, wr_err, wr_sync, wr_baud, wr_data, rd_data;
    assign wr_mode = WR && addr_hit(ADDR, ASC_ADDR_MODE);
    assign wr_err = WR && addr_hit(ADDR, ASC_ADDR_ERR);
    assign wr_sync = WR && addr_hit(ADDR, ASC_ADDR_SYNC);
    assign wr_baud = WR && addr_hit(ADDR, ASC_ADDR_BAUD);
    assign wr_data = WR && addr_hit(ADDR, ASC_ADDR_DATA);
    assign rd_data = RD && addr_hit(ADDR, ASC_ADDR_DATA);

    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_r <= asc_mode_t'(ASC_MODE_RESET);
            baud_r <= ASC_BAUD_RESET;
        end else begin
            if (wr_mode) begin
                mode_r <= asc_mode_t'(WDATA);
            end
            if (wr_baud) begin
                baud_r <= WDATA;
            end
        end
    end

    // only the three defined bits store; the rest read zero
    always_ff @(posedge CLK) begin
        if (RST) begin
            sync_r <= ASC_SYNC_RESET;
        end else if (wr_sync) begin
            sync_r <= WDATA & ASC_SYNC_WMASK;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            SYNC_MODE_ENABLE <= 1'b0;
            FIRST_BIT_ORDER <= 1'b0;
            SYNC_CLOCK_SOURCE <= 1'b0;
        end else begin
            SYNC_MODE_ENABLE <= sync_r[ASC_SYNC_EN_BIT];
            FIRST_BIT_ORDER <= sync_r[ASC_SYNC_ORDER_BIT];
            SYNC_CLOCK_SOURCE <= sync_r[ASC_SYNC_CLK_BIT];
        end
    end

    // read data appears the cycle after RD and holds until the next read
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                ASC_ADDR_MODE: RDATA <= mode_r;
                ASC_ADDR_ERR: RDATA <= err_r;
                ASC_ADDR_SYNC: RDATA <= sync_r;
                ASC_ADDR_BAUD: RDATA <= baud_r;
                ASC_ADDR_DATA: RDATA <= rxb_r;
                default: RDATA <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit timing
    logic src_tick;
    logic [ASC_CNT_W-1:0] bit_last;
    logic [ASC_CNT_W-1:0] half_last;

    asc_baud_prescaler u_prescaler (
        .clk(CLK),
        .rst(RST),
        .clk_internal(mode_r.clk_int),
        .prescale_sel(baud_r[7:4]),
        .ext_clk(EXT_BAUD_CLK),
        .src_tick(src_tick)
    );

    // one bit lasts k+16 source ticks
    assign bit_last = ASC_CNT_W'(ASC_CNT_BASE - 1) + {1'b0, baud_r[3:0]};
    assign half_last = ((ASC_CNT_W'(ASC_CNT_BASE) + {1'b0, baud_r[3:0]}) >> 1) - 5'h01;

    ////////////////////////////////////////////////////////////////////////////
    // transmitter
    logic fifo_valid, tx_load, tx_busy_r, tx_bit_end;
    logic [7:0] fifo_data;
    logic [ASC_FRAME_MAX-1:0] tx_sh_r;
    logic [3:0] tx_left_r;
    logic [ASC_CNT_W-1:0] tx_cnt_r;

    asc_tx_fifo #(
        .WIDTH(ASC_DATA_W),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .clk(CLK),
        .rst(RST),
        .in_valid(wr_data),
        .in_data(WDATA),
        .in_ready(TX_READY),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(tx_load)
    );

    assign tx_load = !tx_busy_r && mode_r.tx_en && fifo_valid;
    assign tx_bit_end = tx_busy_r && src_tick && (tx_cnt_r == bit_last);

    // clearing transmit enable abandons the frame and idles the line
    always_ff @(posedge CLK) begin
        if (RST || !mode_r.tx_en) begin
            tx_busy_r <= 1'b0;
            tx_sh_r <= '1;
            tx_left_r <= 4'h0;
            tx_cnt_r <= '0;
        end else if (tx_load) begin
            tx_busy_r <= 1'b1;
            tx_sh_r <= tx_frame(fifo_data, mode_r);
            tx_left_r <= tx_bits(mode_r);
            tx_cnt_r <= '0;
        end else if (tx_bit_end) begin
            tx_cnt_r <= '0;
            tx_sh_r <= {1'b1, tx_sh_r[ASC_FRAME_MAX-1:1]};
            tx_left_r <= tx_left_r - 4'h1;
            if (tx_left_r == 4'h1) begin
                tx_busy_r <= 1'b0;
            end
        end else if (tx_busy_r && src_tick) begin
            tx_cnt_r <= tx_cnt_r + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            TXD <= 1'b1;
            TRANSMIT_DONE_IRQ <= 1'b0;
        end else begin
            TXD <= tx_busy_r ? tx_sh_r[0] : 1'b1;
            TRANSMIT_DONE_IRQ <= tx_bit_end && (tx_left_r == 4'h1) && mode_r.tx_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // receiver
    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP
    } asc_rx_state_t;

    asc_rx_state_t rx_state_r;
    logic [ASC_CNT_W-1:0] rx_cnt_r;
    logic [2:0] rx_idx_r;
    logic [7:0] rx_sh_r;
    logic rx_par_r;
    logic rx_full_tick, frame_end;
    logic [7:0] rx_word;
    logic par_err, frm_err, ovr_err, any_err;
    logic rx_done_pend_r;
    assign rx_full_tick = src_tick && (rx_cnt_r == bit_last);
    // disable wins at any point of the frame
    always_ff @(posedge CLK) begin
        if (RST || !mode_r.rx_en) begin
            rx_state_r <= RX_IDLE;
            rx_cnt_r <= '0;
            rx_idx_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_par_r <= 1'b0;
        end else begin
            case (rx_state_r)
                RX_IDLE: begin
                    rx_state_r <= RXD ? RX_IDLE : RX_START;
                    rx_cnt_r <= '0;
                end
                RX_START: begin
                    if (src_tick) begin
                        if (rx_cnt_r == half_last) begin
                            rx_cnt_r <= '0;
                            rx_idx_r <= 3'h0;
                            rx_state_r <= RXD ? RX_IDLE : RX_DATA;
                        end else begin
                            rx_cnt_r <= rx_cnt_r + 1'b1;
                        end
                    end
                end
                RX_DATA, RX_PARITY, RX_STOP: begin
                    if (rx_full_tick) begin
                        rx_cnt_r <= '0;
                        if (rx_state_r == RX_DATA) begin
                            rx_sh_r <= {RXD, rx_sh_r[7:1]};
                            rx_idx_r <= rx_idx_r + 1'b1;
                            if (rx_idx_r == (mode_r.char8 ? 3'h7 : 3'h6)) begin
                                rx_state_r <= parity_on(mode_r) ? RX_PARITY : RX_STOP;
                            end
                        end else if (rx_state_r == RX_PARITY) begin
                            rx_par_r <= RXD;
                            rx_state_r <= RX_STOP;
                        end else begin
                            rx_state_r <= RX_IDLE;
                        end
                    end else if (src_tick) begin
                        rx_cnt_r <= rx_cnt_r + 1'b1;
                    end
                end
                default: rx_state_r <= RX_IDLE;
            endcase
        end
    end

    assign frame_end = mode_r.rx_en && (rx_state_r == RX_STOP) && rx_full_tick;
    assign rx_word = mode_r.char8 ? rx_sh_r : {1'b0, rx_sh_r[7:1]};
    always_comb begin
        case (mode_r.parity)
            ASC_PAR_EVEN: par_err = ^{rx_word, rx_par_r};
            ASC_PAR_ODD: par_err = ~^{rx_word, rx_par_r};
            default: par_err = 1'b0;
        endcase
    end

    assign frm_err = !RXD;
    assign ovr_err = rxb_full_r;
    assign any_err = par_err || frm_err || ovr_err;

    // faulty data is loaded too; a frame end wins over the read that would clear full
    always_ff @(posedge CLK) begin
        if (RST) begin
            rxb_r <= ASC_RXB_RESET;
            rxb_full_r <= 1'b0;
        end else if (frame_end) begin
            rxb_r <= rx_word;
            rxb_full_r <= 1'b1;
        end else if (rd_data) begin
            rxb_full_r <= 1'b0;
        end
    end

    // a completed frame replaces the flags; a buffer read clears them
    always_ff @(posedge CLK) begin
        if (RST) begin
            rx_err_r <= 3'h0;
        end else if (frame_end) begin
            rx_err_r <= {par_err, frm_err, ovr_err};
        end else if (rd_data) begin
            rx_err_r <= 3'h0;
        end
    end

    // set wins over a clear written in the same cycle
    always_ff @(posedge CLK) begin
        if (RST) begin
            tx_done_r <= 1'b0;
        end else if (tx_bit_end && (tx_left_r == 4'h1)) begin
            tx_done_r <= 1'b1;
        end else if (wr_err && WDATA[ASC_ERR_TXDONE_BIT]) begin
            tx_done_r <= 1'b0;
        end
    end
    assign err_r = {tx_done_r, 4'h0, rx_err_r};

    // error interrupt first, done one cycle later and only if still enabled
    always_ff @(posedge CLK) begin
        if (RST) begin
            RECEIVE_ERROR_IRQ <= 1'b0;
            rx_done_pend_r <= 1'b0;
            RECEIVE_DONE_IRQ <= 1'b0;
        end else begin
            RECEIVE_ERROR_IRQ <= frame_end && any_err;
            rx_done_pend_r <= frame_end && (!any_err || !mode_r.err_mask);
            RECEIVE_DONE_IRQ <= rx_done_pend_r && mode_r.rx_en;
        end
    end

endmodule

// ==== asc_pkg.sv ====
// asc_pkg: register map, field layouts, reset values and counts for the async serial channel.
// assumes a byte-wide cpu register port and one 100 MHz system clock.
package asc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses
    localparam logic [15:0] ASC_ADDR_MODE = 16'hff70;
    localparam logic [15:0] ASC_ADDR_ERR = 16'hff71;
    localparam logic [15:0] ASC_ADDR_SYNC = 16'hff72;
    localparam logic [15:0] ASC_ADDR_BAUD = 16'hff73;
    localparam logic [15:0] ASC_ADDR_DATA = 16'hff74;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and masks
    localparam logic [7:0] ASC_MODE_RESET = 8'h00;
    localparam logic [7:0] ASC_BAUD_RESET = 8'h00;
    localparam logic [7:0] ASC_SYNC_RESET = 8'h00;
    localparam logic [7:0] ASC_RXB_RESET = 8'h00;
    localparam logic [7:0] ASC_SYNC_WMASK = 8'h86;
    localparam int ASC_SYNC_EN_BIT = 7;
    localparam int ASC_SYNC_ORDER_BIT = 2;
    localparam int ASC_SYNC_CLK_BIT = 1;
    localparam int ASC_ERR_TXDONE_BIT = 7;

    ////////////////////////////////////////////////////////////////////////////
    // counts
    localparam int ASC_CNT_BASE = 16;
    localparam int ASC_CNT_W = 5;
    localparam int ASC_FRAME_MAX = 12;
    localparam int ASC_TX_FIFO_DEPTH = 32;
    localparam int ASC_DATA_W = 8;
    localparam int ASC_PRESCALE_W = 11;
    localparam logic [3:0] ASC_N_DEFAULT = 4'd11;
    localparam logic [3:0] ASC_SEL_N1 = 4'h5;
    localparam logic [3:0] ASC_SEL_N10 = 4'he;

    typedef enum logic [1:0] {
        ASC_PAR_NONE = 2'h0,
        ASC_PAR_ZERO = 2'h1,
        ASC_PAR_ODD = 2'h2,
        ASC_PAR_EVEN = 2'h3
    } asc_parity_t;

    // uart mode register layout, msb first
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        asc_parity_t parity;
        logic char8;
        logic stop2;
        logic err_mask;
        logic clk_int;
    } asc_mode_t;

    // error status register layout, msb first
    typedef struct packed {
        logic tx_done;
        logic [3:0] zero;
        logic parity_err;
        logic framing_err;
        logic overrun_err;
    } asc_err_t;

endpackage

// ==== asc_tx_fifo.sv ====
// asc_tx_fifo: synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module asc_tx_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    // ready is registered so the block's ready port comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_nxt;
            in_ready <= (count_nxt != (AW + 1)'(DEPTH));
        end
    end
endmodule

// ==== asc_baud_prescaler.sv ====
// asc_baud_prescaler: source tick for the 5-bit bit counters.
// assumes the external clock pin is synchronous to clk and slower than clk/2.
`timescale 1ns/1ps
module asc_baud_prescaler
    import asc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_internal,
    input wire logic [3:0] prescale_sel,
    input wire logic ext_clk,
    output logic src_tick
);
    // prohibited selections fall back to the slowest divider
    function automatic logic [3:0] sel_to_n(input logic [3:0] sel);
        if (sel >= ASC_SEL_N1 && sel <= ASC_SEL_N10) begin
            return sel - 4'h4;
        end
        return ASC_N_DEFAULT;
    endfunction

    logic [ASC_PRESCALE_W-1:0] div_r;
    logic [ASC_PRESCALE_W-1:0] mask;
    logic ext_prev_r;
    logic ext_half_r;

    assign mask = ASC_PRESCALE_W'((12'h001 << sel_to_n(prescale_sel)) - 12'h001);

    always_ff @(posedge clk) begin
        if (rst) begin
            div_r <= '0;
            ext_prev_r <= 1'b0;
            ext_half_r <= 1'b0;
            src_tick <= 1'b0;
        end else begin
            div_r <= div_r + 1'b1;
            ext_prev_r <= ext_clk;
            if (clk_internal) begin
                src_tick <= ((div_r & mask) == mask);
            end else begin
                // pin clock is halved before the bit counter
                if (ext_clk && !ext_prev_r) begin
                    ext_half_r <= !ext_half_r;
                end
                src_tick <= ext_clk && !ext_prev_r && ext_half_r;
            end
        end
    end
endmodule

// ==== asc_uart_props.sv ====
// asc_uart_props: port-level checks for asc_uart.
// assumes it is bound to asc_uart and sees only its ports.
`timescale 1ns/1ps
module asc_uart_props
    import asc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [15:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    input wire logic TXD,
    input wire logic TRANSMIT_DONE_IRQ,
    input wire logic RECEIVE_DONE_IRQ,
    input wire logic RECEIVE_ERROR_IRQ,
    input wire logic SYNC_MODE_ENABLE,
    input wire logic FIRST_BIT_ORDER,
    input wire logic SYNC_CLOCK_SOURCE
);
    asc_mode_t mode_r;
    logic [2:0] sync_r;
    always_ff @(posedge CLK) begin
        if (RST) mode_r <= ASC_MODE_RESET;
        else if (WR && ADDR == ASC_ADDR_MODE) mode_r <= asc_mode_t'(WDATA);
    end
    always_ff @(posedge CLK) begin
        if (RST) sync_r <= 3'h0;
        else if (WR && ADDR == ASC_ADDR_SYNC) sync_r <= {WDATA[7], WDATA[2], WDATA[1]};
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    sequence s_sync_wr;
        WR && ADDR == ASC_ADDR_SYNC;
    endsequence
    sequence s_rd_clear;
        RD && ADDR == ASC_ADDR_DATA ##2 RD && ADDR == ASC_ADDR_ERR;
    endsequence
    property p_sync;
        s_sync_wr ##1 !(WR && ADDR == ASC_ADDR_SYNC) |=>
            {SYNC_MODE_ENABLE, FIRST_BIT_ORDER, SYNC_CLOCK_SOURCE} == sync_r;
    endproperty
    a_sync: assert property (p_sync) else $error("sync pins differ from written bits");
    // shortest bit is 32 clocks, so a start shorter than 8 is wrong
    property p_start;
        $fell(TXD) |-> !TXD [*8];
    endproperty
    a_start: assert property (p_start) else $error("start bit too short");
    property p_tx_pulse;
        TRANSMIT_DONE_IRQ |=> !TRANSMIT_DONE_IRQ;
    endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("transmit done not a pulse");
    property p_tx_end;
        TRANSMIT_DONE_IRQ |-> TXD && $past(TXD, 8);
    endproperty
    a_tx_end: assert property (p_tx_end) else $error("transmit done before stop bit");
    property p_mask;
        RECEIVE_ERROR_IRQ && mode_r.err_mask |=> !RECEIVE_DONE_IRQ [*2];
    endproperty
    a_mask: assert property (p_mask) else $error("masked error gave receive done");
    property p_nomask;
        RECEIVE_ERROR_IRQ && !mode_r.err_mask && mode_r.rx_en |=> RECEIVE_DONE_IRQ;
    endproperty
    a_nomask: assert property (p_nomask) else $error("receive done missing after error");
    property p_rx_off;
        !mode_r.rx_en [*4] |-> !RECEIVE_DONE_IRQ && !RECEIVE_ERROR_IRQ;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("receive irq while disabled");
    property p_stat_clr;
        s_rd_clear |=> RDATA[2:0] == 3'h0;
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("status kept after buffer read");
endmodule

// ==== asc_remote.sv ====
// asc_remote: far-end serial transceiver on the data lines.
// assumes BT system clocks per bit; it has no clock of its own.
`timescale 1ns/1ps
module asc_remote #(
    parameter int BT = 32
) (
    input wire logic clk,
    input wire logic txd,
    output logic rxd
);
    logic [10:0] got;
    initial rxd = 1'h1;
    // last bit cut past its centre so a low stop ends early
    task automatic send(input logic [10:0] bits, input int n);
        rxd <= 1'h0;
        repeat (BT) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            repeat ((i == n - 1) ? BT / 2 + 8 : BT) @(posedge clk);
        end
        rxd <= 1'h1;
    endtask
    always begin
        @(negedge txd);
        repeat (BT / 2) @(posedge clk);
        for (int i = 0; i < 11; i++) begin
            repeat (BT) @(posedge clk);
            got[i] = txd;
        end
    end
endmodule

// ==== tb_asc_uart.sv ====
// tb_asc_uart: self-checking bench for asc_uart.
// assumes asc_remote on the serial lines; baud set to 32 clocks a bit.
`timescale 1ns/1ps
module tb_asc_uart;
    import asc_pkg::*;
    logic CLK, RST, WR, RD, RXD, TXD, TX_READY, TXI, RXI, REI, SME, FBO, SCS;
    logic [15:0] ADDR;
    logic [7:0] WDATA, RDATA, rv;
    logic [10:0] f;
    int failures, num_checks, n_tx, n_rd, n_re;
    asc_uart #(.TX_DEPTH(4)) i_asc_uart(.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .RXD, .TXD,
        .EXT_BAUD_CLK(1'h0), .TX_READY, .TRANSMIT_DONE_IRQ(TXI), .RECEIVE_DONE_IRQ(RXI),
        .RECEIVE_ERROR_IRQ(REI), .SYNC_MODE_ENABLE(SME), .FIRST_BIT_ORDER(FBO), .SYNC_CLOCK_SOURCE(SCS));
    asc_remote #(.BT(32)) i_asc_remote(.clk(CLK), .txd(TXD), .rxd(RXD));
    initial begin
        CLK = 1'h0;
        forever #5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        n_tx += int'(TXI === 1'h1);
        n_rd += int'(RXI === 1'h1);
        n_re += int'(REI === 1'h1);
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'h1;
        @(posedge CLK);
        WR <= 1'h0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [15:0] a);
        ADDR <= a;
        RD <= 1'h1;
        @(posedge CLK);
        RD <= 1'h0;
        @(posedge CLK);
        rv = RDATA;
    endtask
    task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] s);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wait_for(ref int c, input int n);
        for (int i = 0; i < 20000 && c < n; i++) @(posedge CLK);
        chk("irq count", n, c);
    endtask
    function automatic logic [10:0] frm(input logic [7:0] d, input logic c8, input logic [1:0] pm);
        logic p;
        int nb;
        nb = c8 ? 8 : 7;
        p = ^(c8 ? d : {1'h0, d[6:0]});
        frm = 11'h7ff;
        for (int i = 0; i < nb; i++)
            frm[i] = d[i];
        if (pm != 2'h0) frm[nb] = (pm == 2'h3) ? p : (pm == 2'h2) ? ~p : 1'h0;
    endfunction
    function automatic logic [7:0] md(input logic [1:0] pm, input logic c8, input logic mk);
        return {2'h3, pm, c8, 1'h0, mk, 1'h1}; // internal baud source
    endfunction
    task automatic end_sim;
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_parity;
        for (int m = 0; m < 4; m++) begin
            wr(ASC_ADDR_MODE, md(m[1:0], m[0], 1'h0));
            wr(ASC_ADDR_DATA, 8'hb5);
            wait_for(n_tx, m + 1);
            repeat (96) @(posedge CLK);
            f = frm(8'hb5, m[0], m[1:0]);
            chk("tx frame", f, i_asc_remote.got);
            if (m == 1) f[8] = ~f[8];
            i_asc_remote.send(f, 11);
            rd(ASC_ADDR_ERR);
            chk("rx status", 8'h80, rv);
            rd(ASC_ADDR_DATA);
            chk("rx data", m[0] ? 8'hb5 : 8'h35, rv);
            chk("rx done", m + 1, n_rd);
        end
    endtask
    task automatic t_errors;
        wr(ASC_ADDR_MODE, md(2'h3, 1'h1, 1'h1));
        f = frm(8'h3c, 1'h1, 2'h3);
        f[8] = ~f[8];
        i_asc_remote.send(f, 11);
        rd(ASC_ADDR_ERR);
        chk("parity err", 3'h4, rv[2:0]);
        chk("masked done", 4, n_rd);
        rd(ASC_ADDR_DATA);
        chk("err data", 8'h3c, rv);
        rd(ASC_ADDR_ERR);
        chk("status clr", 3'h0, rv[2:0]);
        wr(ASC_ADDR_MODE, md(2'h0, 1'h1, 1'h0));
        f = frm(8'h81, 1'h1, 2'h0);
        f[8] = 1'h0;
        i_asc_remote.send(f, 9); // low tail must not pass as a start
        rd(ASC_ADDR_ERR);
        chk("framing err", 3'h2, rv[2:0]);
        chk("open done", 5, n_rd);
        rd(ASC_ADDR_DATA);
        i_asc_remote.send(frm(8'h11, 1'h1, 2'h0), 11);
        i_asc_remote.send(frm(8'h22, 1'h1, 2'h0), 11);
        rd(ASC_ADDR_ERR);
        chk("overrun", 3'h1, rv[2:0]);
        rd(ASC_ADDR_DATA);
        chk("overrun data", 8'h22, rv);
        chk("error irqs", 3, n_re);
        fork
            i_asc_remote.send(frm(8'h5a, 1'h1, 2'h0), 11);
            begin
                repeat (128) @(posedge CLK);
                wr(ASC_ADDR_MODE, 8'h89);
            end
        join
        rd(ASC_ADDR_DATA);
        chk("held data", 8'h22, rv);
        chk("stopped rx", 7, n_rd);
    endtask
    task automatic t_fill;
        wr(ASC_ADDR_MODE, md(2'h3, 1'h1, 1'h0) | 8'h04); // idle, never aborted
        for (int i = 0; i < 5; i++)
            wr(ASC_ADDR_DATA, 8'h61 + 8'(i));
        chk("fifo full", 1'h0, TX_READY);
        wait_for(n_tx, 9);
        chk("fifo empty", 1'h1, TX_READY);
        repeat (96) @(posedge CLK);
        chk("last frame", frm(8'h65, 1'h1, 2'h3), i_asc_remote.got);
    endtask
    initial begin
        RST = 1'h1;
        WR = 1'h0;
        RD = 1'h0;
        ADDR = 16'h0;
        WDATA = 8'h0;
        repeat (16) @(posedge CLK);
        RST <= 1'h0;
        @(posedge CLK);
        wr(ASC_ADDR_SYNC, 8'hff);
        rd(ASC_ADDR_SYNC);
        chk("sync reg", 8'h86, rv);
        chk("sync pins", 3'h7, {SME, FBO, SCS});
        rd(16'hff7f);
        chk("unmapped", 8'h00, rv);
        wr(ASC_ADDR_BAUD, 8'h50);
        t_parity;
        t_errors;
        t_fill;
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge CLK);
        failures++;
        end_sim;
    end
endmodule
bind asc_uart asc_uart_props i_asc_uart_props(.CLK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .TXD,
    .TRANSMIT_DONE_IRQ, .RECEIVE_DONE_IRQ, .RECEIVE_ERROR_IRQ, .SYNC_MODE_ENABLE, .FIRST_BIT_ORDER,
    .SYNC_CLOCK_SOURCE);
